// file: rx_hw_config_los_mute.sv
// Receive-side configuration decode with loss-of-signal muting and an AHB-Lite register slave.
// Assumes one 20 MHz clock; loss flags, channel rate modes and recovered data arrive on it.
//
// Function
// RULE1: With muting enabled, a channel in loss of signal drives both data outputs low.
// RULE2: With muting disabled, recovered data passes unchanged despite loss of signal.
// RULE3: In host mode the shared mute pin becomes the interrupt request output.
// RULE4: One mute setting governs all three channels together.
// RULE5: Each channel's equalizer follows its own enable input, high enables.
// RULE6: In host mode equalizer enable pins are ignored; board ties them low.
// RULE7: The far side should normally hold equalizer enable pins high.
// RULE8: Threshold select picks one of two threshold sets for all channels.
// RULE9: Threshold select acts only when some channel runs DS3 or STS-1.
// RULE10: Muting starts and stops on data clock edges aligned with the loss flag.
//
// The implementer's own choices: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "rx_cfg_map.svh"

module rx_hw_config_los_mute #(
	parameter int unsigned NUM_CH = `RX_NUM_CH
) (
	input  wire logic               clk_i,
	input  wire logic               rst_n_i,
	// AHB-Lite slave
	input  wire logic               hsel_i,
	input  wire logic [31:0]        haddr_i,
	input  wire logic [1:0]         htrans_i,
	input  wire logic               hwrite_i,
	input  wire logic [2:0]         hsize_i,
	input  wire rx_cfg_pkg::word_t  hwdata_i,
	input  wire logic               hready_i,
	output rx_cfg_pkg::word_t       hrdata_o,
	output logic                    hreadyout_o,
	output logic                    hresp_o,
	// Configuration pins
	input  wire logic               host_mode_pin_i,
	input  wire logic [NUM_CH-1:0]  rx_eq_enable_pin_i,
	input  wire logic               los_threshold_select_i,
	input  wire logic               los_mute_enable_i,
	output logic                    los_mute_enable_o,
	output logic                    los_mute_enable_oe_o,
	// Receive path, same clock
	input  wire logic [NUM_CH-1:0]  ch_fast_rate_i,
	input  wire logic [NUM_CH-1:0]  los_i,
	input  wire logic [NUM_CH-1:0]  rec_pos_i,
	input  wire logic [NUM_CH-1:0]  rec_neg_i,
	output logic      [NUM_CH-1:0]  rx_positive_data_o,
	output logic      [NUM_CH-1:0]  rx_negative_data_o,
	output logic      [NUM_CH-1:0]  rx_eq_on_o,
	output logic                    los_threshold_sel_o,
	output logic                    irq_o
);
	import rx_cfg_pkg::*;

	// Synchronised pin levels
	logic              host_level;
	logic [NUM_CH-1:0] eq_pin_level;
	logic              thr_pin_level;
	logic              mute_pin_level;

	// Software registers
	logic [NUM_CH-1:0] ctrl_eq_q;
	logic              ctrl_mute_q;
	logic              ctrl_thr_q;
	logic [NUM_CH-1:0] int_stat_q;
	logic [NUM_CH-1:0] int_stat_d;
	logic [NUM_CH-1:0] int_mask_q;

	// Applied configuration
	logic              mute_en_q;
	logic              thr_d;
	logic [NUM_CH-1:0] los_prev_q;
	logic [NUM_CH-1:0] muted;

	// Bus data phase state
	logic                 dph_wr_q;
	logic [`RX_ADDR_W-1:0] dph_addr_q;
	word_t                rdata_mux;
	word_t                stat_word;

	// All pins cross into clk_i through two flops before use
	// Straps and the shared mute pin change with no regard to clk_i; a single flop could
	// let a metastable level reach the decode, so two are spent on every pin
	pin_sync #(.WIDTH(NUM_CH + 3)) u_pin_sync (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.pin_i   ({host_mode_pin_i, los_threshold_select_i, los_mute_enable_i, rx_eq_enable_pin_i}),
		.level_o ({host_level, thr_pin_level, mute_pin_level, eq_pin_level})
	);

	// Source selection: pins in hardware mode, registers in host mode
	// In host mode the eq, mute and threshold pins are ignored and the shared mute pin
	// turns into the interrupt output, so its level never feeds the mute decode
	wire [NUM_CH-1:0] eq_src   = host_level ? ctrl_eq_q   : eq_pin_level;   // RULE5 RULE6
	wire              mute_src = host_level ? ctrl_mute_q : mute_pin_level; // RULE3
	wire              thr_src  = host_level ? ctrl_thr_q  : thr_pin_level;
	wire              any_fast = |ch_fast_rate_i;

	// Threshold select is frozen unless some channel runs a fast rate
	// Holding the last applied set avoids a threshold step while no channel uses it,
	// at the cost of a stale select if the pin moved in the meantime
	assign thr_d = any_fast ? thr_src : los_threshold_sel_o; // RULE8 RULE9

	// Loss-of-signal rise events feed the sticky interrupt status
	// Rising edges only: a loss that stays declared raises one event, not one per cycle
	wire [NUM_CH-1:0] los_set = los_i & ~los_prev_q;

	// Address phase capture and register decode
	// Only the low address byte is decoded, so upper address bits alias onto the same words;
	// the data phase follows every accepted address phase by exactly one cycle
	wire              addr_take = hsel_i & hready_i & (htrans_i == HT_NONSEQ || htrans_i == HT_SEQ);
	wire [`RX_ADDR_W-1:0] a_addr = haddr_i[`RX_ADDR_W-1:0];
	wire              wr_ctrl   = dph_wr_q & (dph_addr_q == `OFS_CTRL);
	wire              wr_istat  = dph_wr_q & (dph_addr_q == `OFS_INT_STATUS);
	wire              wr_imask  = dph_wr_q & (dph_addr_q == `OFS_INT_MASK);
	wire [NUM_CH-1:0] istat_clr = wr_istat ? hwdata_i[`INT_LOS_LSB +: NUM_CH] : '0;

	// Set wins over a write-one clear in the same cycle
	// A clear that meets a new event keeps the event, so software never misses a loss
	assign int_stat_d = (int_stat_q & ~istat_clr) | los_set;

	// Interrupt level from the next status value, so it stands one cycle after an event
	wire irq_d = |(int_stat_d & int_mask_q);

	// Status word shows the applied configuration and live loss flags
	always_comb begin
		stat_word = '0;
		stat_word[`STAT_LOS_LSB +: NUM_CH] = los_i;
		stat_word[`STAT_HOST_BIT]          = host_level;
		stat_word[`STAT_EQ_LSB +: NUM_CH]  = rx_eq_on_o;
		stat_word[`STAT_MUTE_BIT]          = mute_en_q;
		stat_word[`STAT_THR_BIT]           = los_threshold_sel_o;
		stat_word[`STAT_FAST_BIT]          = any_fast;
	end

	// Read multiplexer; unmapped offsets read as zero
	always_comb begin
		rdata_mux = '0;
		unique case (a_addr)
			`OFS_CTRL: begin
				rdata_mux[`CTRL_EQ_LSB +: NUM_CH] = ctrl_eq_q;
				rdata_mux[`CTRL_MUTE_BIT]         = ctrl_mute_q;
				rdata_mux[`CTRL_THR_BIT]          = ctrl_thr_q;
			end
			`OFS_STATUS: begin
				rdata_mux = stat_word;
			end
			`OFS_INT_STATUS: begin
				rdata_mux[`INT_LOS_LSB +: NUM_CH] = int_stat_q;
			end
			`OFS_INT_MASK: begin
				rdata_mux[`INT_LOS_LSB +: NUM_CH] = int_mask_q;
			end
			default: begin
				rdata_mux = '0;
			end
		endcase
	end

	// Bus slave: zero wait states, always OKAY
	// Read data is zero outside a read data phase, which keeps stale words off the bus;
	// zero wait states let back-to-back transfers run at one per cycle
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			dph_wr_q    <= 1'b0;
			dph_addr_q  <= '0;
			hrdata_o    <= '0;
			hreadyout_o <= 1'b1;
			hresp_o     <= 1'b0;
		end else begin
			dph_wr_q    <= addr_take & hwrite_i;
			dph_addr_q  <= a_addr;
			hrdata_o    <= (addr_take & ~hwrite_i) ? rdata_mux : '0;
			hreadyout_o <= 1'b1;
			hresp_o     <= 1'b0;
		end
	end

	// Control register: equalizers default on, as most boards want
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl_eq_q   <= {NUM_CH{`CTRL_EQ_RST_BIT}};
			ctrl_mute_q <= `CTRL_MUTE_RST;
			ctrl_thr_q  <= `CTRL_THR_RST;
		end else if (wr_ctrl) begin
			ctrl_eq_q   <= hwdata_i[`CTRL_EQ_LSB +: NUM_CH];
			ctrl_mute_q <= hwdata_i[`CTRL_MUTE_BIT];
			ctrl_thr_q  <= hwdata_i[`CTRL_THR_BIT];
		end
	end

	// Interrupt mask and sticky status
	// The previous loss level is reset low, the idle level of the flag, so no false event follows reset
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			int_mask_q <= {NUM_CH{`INT_MASK_RST_BIT}};
			int_stat_q <= '0;
			los_prev_q <= '0;
		end else begin
			if (wr_imask) begin
				int_mask_q <= hwdata_i[`INT_LOS_LSB +: NUM_CH];
			end
			int_stat_q <= int_stat_d;
			los_prev_q <= los_i;
		end
	end

	// Applied configuration and the shared pin; in host mode the pin carries the interrupt
	// Every applied setting leaves a flop, so the analog sections never see a decode glitch,
	// and the output enable follows the synchronised strap so the pin never fights the board
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rx_eq_on_o           <= '0;
			mute_en_q            <= 1'b0;
			los_threshold_sel_o  <= `THR_OUT_RST;
			irq_o                <= 1'b0;
			los_mute_enable_o    <= 1'b0;
			los_mute_enable_oe_o <= 1'b0;
		end else begin
			rx_eq_on_o           <= eq_src;             // RULE5 RULE6
			mute_en_q            <= mute_src;           // RULE4
			los_threshold_sel_o  <= thr_d;              // RULE8 RULE9
			irq_o                <= irq_d;
			los_mute_enable_o    <= host_level & irq_d; // RULE3
			los_mute_enable_oe_o <= host_level;         // RULE3
		end
	end

	// One gate per channel, all fed by the same mute setting
	// The recovered clock is modelled by clk_i, so each gate flop sits in this same domain
	for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_gate
		rx_mute_gate u_gate (
			.clk_i     (clk_i),
			.rst_n_i   (rst_n_i),
			.mute_en_i (mute_en_q),
			.los_i     (los_i[ch]),
			.pos_i     (rec_pos_i[ch]),
			.neg_i     (rec_neg_i[ch]),
			.pos_o     (rx_positive_data_o[ch]),
			.neg_o     (rx_negative_data_o[ch]),
			.muted_o   (muted[ch])
		); // RULE4 RULE10
	end

	// Checks below all run on clk_i and stay quiet while reset is held
	// Each one but chk_irq_low and chk_rdata_idle compares against the rule it guards; those two restate the decode that drives them
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	chk_eq_follows_pin: assert property ( // RULE5
		!host_level |=> rx_eq_on_o == $past(eq_pin_level))
		else $error("Equalizer enable does not follow its pin");

	chk_eq_pins_ignored: assert property ( // RULE6
		(host_level && $stable(ctrl_eq_q)) |=> rx_eq_on_o == $past(ctrl_eq_q))
		else $error("Equalizer pins acted on in host mode");

	chk_pin_drives_irq: assert property ( // RULE3
		host_level |=> los_mute_enable_oe_o && (los_mute_enable_o == irq_o))
		else $error("Shared pin not driving interrupt in host mode");

	chk_pin_released: assert property ( // RULE3
		!host_level |=> !los_mute_enable_oe_o && !los_mute_enable_o)
		else $error("Shared pin driven outside host mode");

	chk_thr_applied: assert property ( // RULE8
		(any_fast && !host_level) |=> los_threshold_sel_o == $past(thr_pin_level))
		else $error("Threshold select not applied");

	chk_thr_disregarded: assert property ( // RULE9
		!any_fast |=> $stable(los_threshold_sel_o))
		else $error("Threshold select changed with no fast channel");

	chk_mute_all_channels: assert property ( // RULE4
		(mute_en_q && (&los_i)) |=> (rx_positive_data_o == '0) && (rx_negative_data_o == '0))
		else $error("Mute setting not applied to every channel");

	chk_mute_from_pin: assert property ( // RULE1
		(!host_level && mute_pin_level) |=> mute_en_q)
		else $error("Mute enable pin not taken");

	chk_irq_level: assert property (
		(|(int_stat_q & int_mask_q) && !wr_istat) |=> irq_o)
		else $error("Interrupt low with unmasked status set");

	chk_status_set_wins: assert property (
		(|los_set) |=> |(int_stat_q & $past(los_set)))
		else $error("Loss event lost from interrupt status");

	chk_bus_zero_wait: assert property (
		addr_take |=> hreadyout_o && !hresp_o)
		else $error("Bus answer not immediate OKAY");

	// Rails of a muted channel stay low for as long as its muted flag stands
	chk_muted_rails_low: assert property ( // RULE1
		((rx_positive_data_o | rx_negative_data_o) & muted) == '0)
		else $error("Muted channel shows data");

	chk_mute_pin_off: assert property ( // RULE2
		(!host_level && !mute_pin_level) |=> !mute_en_q)
		else $error("Muting applied with mute pin low");

	chk_mute_from_reg: assert property ( // RULE3
		host_level |=> mute_en_q == $past(ctrl_mute_q))
		else $error("Shared pin taken as mute input in host mode");

	chk_thr_from_reg: assert property ( // RULE8
		(any_fast && host_level) |=> los_threshold_sel_o == $past(ctrl_thr_q))
		else $error("Threshold select not taken from control in host mode");

	// Register side: writes land, write-one-to-clear works and read data stays quiet
	chk_ctrl_written: assert property (
		wr_ctrl |=> ctrl_eq_q == $past(hwdata_i[`CTRL_EQ_LSB +: NUM_CH]))
		else $error("Control write did not land");

	chk_mask_written: assert property (
		wr_imask |=> int_mask_q == $past(hwdata_i[`INT_LOS_LSB +: NUM_CH]))
		else $error("Mask write did not land");

	chk_w1c_clears: assert property (
		(wr_istat && !(|los_set)) |=> (int_stat_q & $past(istat_clr)) == '0)
		else $error("Write-one did not clear status");

	chk_status_holds: assert property (
		(!(|los_set) && !wr_istat) |=> int_stat_q == $past(int_stat_q))
		else $error("Status changed with no event and no clear");

	chk_irq_low: assert property (
		!(|(int_stat_d & int_mask_q)) |=> !irq_o)
		else $error("Interrupt high with no unmasked status");

	chk_rdata_idle: assert property (
		!(addr_take && !hwrite_i) |=> hrdata_o == '0)
		else $error("Read data not zero outside a read");

	chk_unmapped_zero: assert property (
		(addr_take && !hwrite_i && (a_addr > `OFS_INT_MASK)) |=> hrdata_o == '0)
		else $error("Unmapped word read as nonzero");

endmodule

`default_nettype wire

// file: rx_cfg_map.svh
// Address map, field positions and reset values of the receive configuration block.
// Assumes a 32-bit AHB-Lite slave where each register takes one aligned word.
`ifndef RX_CFG_MAP_SVH
`define RX_CFG_MAP_SVH

`define RX_NUM_CH        3
`define RX_ADDR_W        8

// Byte offsets of the registers
`define OFS_CTRL         8'h00
`define OFS_STATUS       8'h04
`define OFS_INT_STATUS   8'h08
`define OFS_INT_MASK     8'h0C

// Control register fields (host mode settings)
`define CTRL_EQ_LSB      0
`define CTRL_MUTE_BIT    3
`define CTRL_THR_BIT     4

// Status register fields
`define STAT_LOS_LSB     0
`define STAT_HOST_BIT    3
`define STAT_EQ_LSB      4
`define STAT_MUTE_BIT    7
`define STAT_THR_BIT     8
`define STAT_FAST_BIT    9

// Interrupt status and mask fields: one bit per channel
`define INT_LOS_LSB      0

// Reset values
`define CTRL_EQ_RST_BIT  1'b1
`define CTRL_MUTE_RST    1'b0
`define CTRL_THR_RST     1'b0
`define INT_MASK_RST_BIT 1'b0
`define THR_OUT_RST      1'b0

`endif

// file: rx_cfg_pkg.sv
// Types shared by the receive configuration block and its testbench.
// Assumes the map header supplies all numeric offsets and positions.
package rx_cfg_pkg;

	typedef logic [31:0] word_t;

	// AHB-Lite transfer types
	typedef enum logic [1:0] {
		HT_IDLE   = 2'b00,
		HT_BUSY   = 2'b01,
		HT_NONSEQ = 2'b10,
		HT_SEQ    = 2'b11
	} htrans_e;

endpackage

// file: pin_sync.sv
// Two-flop synchroniser for level inputs that arrive from device pins.
// Assumes the inputs are quasi-static levels; the first stage feeds only the second.
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
	parameter int unsigned WIDTH = 1
) (
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	input  wire logic [WIDTH-1:0] pin_i,
	output logic      [WIDTH-1:0] level_o
);

	logic [WIDTH-1:0] meta_q;

	// Two stages; nothing but the second stage reads meta_q
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_q  <= '0;
			level_o <= '0;
		end else begin
			meta_q  <= pin_i;
			level_o <= meta_q;
		end
	end

endmodule

`default_nettype wire

// file: rx_mute_gate.sv
// Per-channel gate that forces recovered data low while loss of signal is declared.
// Assumes data and the loss flag are on clk_i, which stands in for the recovered clock.
`timescale 1ns/1ps
`default_nettype none

module rx_mute_gate (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	input  wire logic mute_en_i,
	input  wire logic los_i,
	input  wire logic pos_i,
	input  wire logic neg_i,
	output logic      pos_o,
	output logic      neg_o,
	output logic      muted_o
);

	wire mute_now = mute_en_i & los_i;

	// Gate sits in the data register so muting edges line up with the flag
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pos_o   <= 1'b0;
			neg_o   <= 1'b0;
			muted_o <= 1'b0;
		end else begin
			pos_o   <= pos_i & ~mute_now; // RULE1 RULE2 RULE10
			neg_o   <= neg_i & ~mute_now; // RULE1 RULE2 RULE10
			muted_o <= mute_now;
		end
	end

	chk_mute_forces_low: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE1
		(mute_en_i && los_i) |=> (!pos_o && !neg_o))
		else $error("Data not forced low during loss of signal");

	chk_pass_when_off: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE2
		!mute_en_i |=> (pos_o == $past(pos_i)) && (neg_o == $past(neg_i)))
		else $error("Data altered while muting disabled");

	chk_mute_edge_aligned: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE10
		($rose(los_i) && mute_en_i) |=> muted_o ##1 (muted_o || !$past(los_i) || !$past(mute_en_i)))
		else $error("Muting not aligned to loss flag");

endmodule

`default_nettype wire

// file: rx_framer_model.sv
// Far-side framer model that takes the recovered positive and negative rails.
// Assumes the recovered clock is the block clock and data are sampled on its rising edge.
`timescale 1ns/1ps
`default_nettype none

module rx_framer_model #(
	parameter int unsigned NUM_CH = 3
) (
	input  wire logic              clk_i,
	input  wire logic [NUM_CH-1:0] pos_i,
	input  wire logic [NUM_CH-1:0] neg_i,
	output logic      [NUM_CH-1:0] pos_o,
	output logic      [NUM_CH-1:0] neg_o
);
	// Capture both rails each cycle; a framer applies no back-pressure to the line side
	always_ff @(posedge clk_i) begin
		pos_o <= pos_i;
		neg_o <= neg_i;
	end
endmodule
`default_nettype wire

// file: tb_rx_hw_config_los_mute.sv
// Self-checking bench for the receive configuration block with its framer model.
// Assumes one 20 MHz clock and a single AHB-Lite slave whose hreadyout is the bus hready.
`timescale 1ns/1ps
`default_nettype none
`include "rx_cfg_map.svh"

module tb_rx_hw_config_los_mute;
	import rx_cfg_pkg::*;
	localparam int unsigned NCH = `RX_NUM_CH;
	logic        clk_i = 1'b0, rst_n_i = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0, hready, hresp;
	word_t       hwdata = '0, hrdata;
	logic        host = 1'b0, thr_pin = 1'b0, mute_drv = 1'b0, mute_o, mute_oe, thr_o, irq;
	logic [2:0]  eq_pin = 3'h7, fast = 3'h0, los = 3'h0, rpos = 3'h0, rneg = 3'h0;
	logic [2:0]  opos, oneg, eq_on, fpos, fneg;
	int          num_errors = 0, samples_checked = 0;
	// The shared mute pin is driven by the block only while its enable is high
	wire logic   mute_wire = mute_oe ? mute_o : mute_drv;

	always #25 clk_i = ~clk_i;

	rx_hw_config_los_mute #(.NUM_CH(NCH)) dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .hsel_i(1'b1),
		.haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
		.hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
		.host_mode_pin_i(host), .rx_eq_enable_pin_i(eq_pin), .los_threshold_select_i(thr_pin),
		.los_mute_enable_i(mute_wire), .los_mute_enable_o(mute_o), .los_mute_enable_oe_o(mute_oe),
		.ch_fast_rate_i(fast), .los_i(los), .rec_pos_i(rpos), .rec_neg_i(rneg),
		.rx_positive_data_o(opos), .rx_negative_data_o(oneg), .rx_eq_on_o(eq_on),
		.los_threshold_sel_o(thr_o), .irq_o(irq));

	rx_framer_model #(.NUM_CH(NCH)) framer_u (.clk_i(clk_i), .pos_i(opos), .neg_i(oneg),
		.pos_o(fpos), .neg_o(fneg));

	task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			num_errors++;
			$display("FAIL %s expected %h seen %h", what, e, g);
		end
	endtask

	// One single AHB-Lite transfer; waits on hready, never on a fixed count
	task automatic bus(input logic wr, input logic [7:0] a, input word_t wd, output word_t r);
		@(posedge clk_i);
		htrans <= HT_NONSEQ;
		haddr <= {24'h0, a};
		hwrite <= wr;
		do @(posedge clk_i); while (hready !== 1'b1);
		htrans <= HT_IDLE;
		hwdata <= wd;
		do @(posedge clk_i); while (hready !== 1'b1);
		r = hrdata;
		check("resp", 32'h0, 32'(hresp));
		check("ready", 32'h1, 32'(hready));
	endtask

	task automatic wr(input logic [7:0] a, input word_t d);
		word_t r;
		bus(1'b1, a, d, r);
	endtask

	task automatic rd(input logic [7:0] a, input word_t e);
		word_t r;
		bus(1'b0, a, '0, r);
		check("reg", e, r);
	endtask

	// Pins pass two sync flops and an output flop, so five edges is ample
	task automatic settle();
		repeat (5) @(posedge clk_i);
		@(negedge clk_i);
	endtask

	// Random line data against a model of the gate, checked at the block and at the framer
	task automatic run_data(input logic m);
		logic [2:0] ep, en, pp, pn;
		@(posedge clk_i);
		mute_drv <= m;
		repeat (4) @(posedge clk_i);
		for (int i = 0; i < 80; i++) begin
			@(posedge clk_i);
			ep = rpos & ~({3{m}} & los);
			en = rneg & ~({3{m}} & los);
			rpos <= 3'($urandom_range(7));
			rneg <= 3'($urandom_range(7));
			los <= 3'($urandom_range(7));
			@(negedge clk_i);
			check("pos", 32'(ep), 32'(opos));
			check("neg", 32'(en), 32'(oneg));
			if (i > 0) check("framer", 32'({pp, pn}), 32'({fpos, fneg}));
			pp = ep;
			pn = en;
		end
		$display("test data mute %0d done", m);
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	initial begin
		#(50 * 30000);
		num_errors++;
		end_of_test();
	end

	initial begin
		void'($urandom(32'hF9ADD9FB));
		repeat (20) @(posedge clk_i);
		rst_n_i <= 1'b1;
		// Reset values and an unmapped word
		rd(`OFS_CTRL, 32'h0000_0007);
		rd(`OFS_INT_MASK, 32'h0);
		rd(`OFS_INT_STATUS, 32'h0);
		wr(8'h10, 32'hFFFF_FFFF);
		rd(8'h10, 32'h0);
		$display("test registers done");
		// Per-channel equalizer enables; last value is the usual all-high setting
		for (int k = 0; k < 5; k++) begin
			@(posedge clk_i);
			eq_pin <= (k == 4) ? 3'h7 : 3'($urandom_range(7));
			settle();
			check("eq_on", 32'(eq_pin), 32'(eq_on));
		end
		$display("test equalizer done");
		// Threshold select held while no fast channel, then applied to all
		for (int v = 1; v >= 0; v--) begin
			@(posedge clk_i);
			thr_pin <= v[0];
			fast <= 3'h0;
			settle();
			check("thr_hold", v[0] ? 32'h0 : 32'h1, 32'(thr_o));
			@(posedge clk_i);
			fast <= 3'h1 << $urandom_range(2);
			settle();
			check("thr_sel", 32'(v[0]), 32'(thr_o));
		end
		$display("test threshold done");
		run_data(1'b1);
		run_data(1'b0);
		// Sticky loss events, mask and write-one-to-clear
		@(posedge clk_i);
		los <= 3'h0;
		settle();
		wr(`OFS_INT_STATUS, 32'h7);
		wr(`OFS_INT_MASK, 32'h1);
		rd(`OFS_INT_STATUS, 32'h0);
		@(posedge clk_i);
		los <= 3'h3;
		settle();
		rd(`OFS_INT_STATUS, 32'h3);
		check("irq", 32'h1, 32'(irq));
		wr(`OFS_INT_STATUS, 32'h1);
		rd(`OFS_INT_STATUS, 32'h2);
		settle();
		check("irq_masked", 32'h0, 32'(irq));
		$display("test interrupt done");
		// Host mode: shared pin turns output, equalizer pins ignored
		@(posedge clk_i);
		host <= 1'b1;
		eq_pin <= 3'h5;
		los <= 3'h0;
		settle();
		check("pin_oe", 32'h1, 32'(mute_oe));
		wr(`OFS_CTRL, 32'h0000_000A);
		wr(`OFS_INT_STATUS, 32'h7);
		settle();
		check("eq_host", 32'h2, 32'(eq_on));
		@(posedge clk_i);
		los <= 3'h1;
		settle();
		check("pin_irq", 32'h1, 32'(mute_o));
		wr(`OFS_INT_STATUS, 32'h7);
		settle();
		check("pin_idle", 32'h0, 32'(mute_o));
		// Shared pin now low, control asks for muting: channel 0 in loss must be muted
		@(posedge clk_i);
		rpos <= 3'h7;
		rneg <= 3'h7;
		settle();
		check("pos_host", 32'h6, 32'(opos));
		check("neg_host", 32'h6, 32'(oneg));
		wr(`OFS_CTRL, 32'h0000_001A);
		settle();
		check("thr_host", 32'h1, 32'(thr_o));
		// Loss on ch0, host, eq 010, mute on, threshold high, a fast channel present
		rd(`OFS_STATUS, 32'h0000_03A9);
		$display("test host mode done");
		end_of_test();
	end
endmodule
`default_nettype wire
